// ==== core/tpsr_cfg.svh ====
// Offsets, reset values, codes and counts of the two-port SRAM block.
`ifndef TPSR_CFG_SVH
`define TPSR_CFG_SVH
`define TPSR_CTRL_OFS 4'h0
`define TPSR_STAT_OFS 4'h4
`define TPSR_CTRL_RST 9'h005
`define TPSR_WSEL_LSB 0
`define TPSR_RSEL_LSB 2
`define TPSR_PIPE_BIT 4
`define TPSR_WENH_BIT 5
`define TPSR_RENH_BIT 6
`define TPSR_WINV_BIT 7
`define TPSR_RINV_BIT 8
`define TPSR_STAT_DATA_LSB 4
`define TPSR_W9 2'h1
`define TPSR_W18 2'h2
`define TPSR_WORDS 9'h100
`define TPSR_PRELOAD_BITS 13'h1200
`define TPSR_WORD_LAST 5'h11
`endif

// ==== core/tpsr_pkg.sv ====
// Types shared by the two-port SRAM block.
package tpsr_pkg;
    typedef struct packed {
        logic rclk_inv;
        logic wclk_inv;
        logic ren_high;
        logic wen_high;
        logic pipe;
        logic [1:0] read_width_sel;
        logic [1:0] write_width_sel;
    } tpsr_ctrl_s;
    typedef struct packed {
        logic [8:0] addr;
        logic [17:0] data;
    } tpsr_port_s;
    typedef enum logic [1:0] {
        PL_IDLE,
        PL_SHIFT,
        PL_DONE
    } tpsr_pl_e;
endpackage

// ==== core/tpsr_top.sv ====
// Two-port synchronous SRAM with Wishbone control and serial preload.
// How it works
// (R1) Separate write and read ports; both may act in the same cycle.
// (R2) Width code 01 is 512x9, 10 is 256x18; 00 and 11 block access.
// (R3) User ties write data bits 17..9 low in nine-bit write mode.
// (R4) In nine-bit read mode only the low nine read bits carry data.
// (R5) User ties address bit 8 low in eighteen-bit mode.
// (R6) Write port acts on write clock, read port on read clock, rising.
// (R7) Enables are active low unless control bits make them active high.
// (R8) Reset low zeroes output, blocks access, clears holds, keeps memory.
// (R9) Pipe low gives data after one read edge, pipe high after two.
// (R10) Non-pipelined read captures address and presents the addressed word.
// (R11) Pipelined read registers the word and presents it next read edge.
// (R12) Write edge with enable active stores write data at write address.
// (R13) Per-port clock inversion bits give falling-edge operation.
// (R14) User keeps read address stable and synchronised around read edge.
// (R15) Serial preload loads all 4608 bits in one operation.
// (R16) Nine-bit words map little-endian onto eighteen-bit words.
// (R17) Width selects stay fixed during operation, never reserved codes.
`timescale 1ns/1ns
`include "tpsr_cfg.svh"
module tpsr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic reset_n_i,
    input wire logic write_clk_i,
    input wire logic read_clk_i,
    input wire logic write_en_i,
    input wire logic read_en_i,
    input wire logic [8:0] write_addr_bus_i,
    input wire logic [17:0] write_data_bus_i,
    input wire logic [8:0] read_addr_bus_i,
    output logic [17:0] read_data_o,
    input wire logic preload_sel_i,
    input wire logic preload_shift_i,
    input wire logic preload_bit_i,
    output logic preload_done_o
);
    tpsr_pkg::tpsr_ctrl_s ctrl_r;
    tpsr_pkg::tpsr_pl_e pl_state_r;
    tpsr_pkg::tpsr_port_s wport_w;
    logic [17:0] mem_r [0:255];
    logic [2:0] sync_r [0:2];
    logic [2:0] filt_r;
    logic [17:0] stage_r;
    logic [17:0] shift_r;
    logic [12:0] pl_cnt_r;
    logic [4:0] pl_bit_r;
    logic [7:0] pl_row_r;

    // Clock and reset pins from outside the clock domain: three flops, change on agreement.
    logic [2:0] pin_w;
    assign pin_w = {read_clk_i, write_clk_i, reset_n_i};
    genvar gp;
    generate
        for (gp = 0; gp < 3; gp = gp + 1) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync_r[gp] <= 3'h0;
                    filt_r[gp] <= 1'b0;
                end else if (ce_i) begin
                    sync_r[gp] <= {sync_r[gp][1:0], pin_w[gp]};
                    if (sync_r[gp][1] == sync_r[gp][2]) begin
                        filt_r[gp] <= sync_r[gp][2];
                    end
                end
            end
        end
    endgenerate

    wire res_act = ~filt_r[0];
    wire w_new = (sync_r[1][1] == sync_r[1][2]) ? sync_r[1][2] : filt_r[1];
    wire r_new = (sync_r[2][1] == sync_r[2][2]) ? sync_r[2][2] : filt_r[2];
    // Inversion moves the active edge without adding any clock path.
    wire w_edge = ce_i & ((w_new ^ ctrl_r.wclk_inv) & // [R6] [R13]
        ~(filt_r[1] ^ ctrl_r.wclk_inv));
    wire r_edge = ce_i & ((r_new ^ ctrl_r.rclk_inv) & // [R6] [R13]
        ~(filt_r[2] ^ ctrl_r.rclk_inv));

    wire w9 = ctrl_r.write_width_sel == `TPSR_W9;
    wire w18 = ctrl_r.write_width_sel == `TPSR_W18;
    wire r9 = ctrl_r.read_width_sel == `TPSR_W9;
    wire r18 = ctrl_r.read_width_sel == `TPSR_W18;
    wire wen_act = write_en_i ~^ ctrl_r.wen_high; // [R7]
    wire ren_act = read_en_i ~^ ctrl_r.ren_high; // [R7]
    wire pl_busy = pl_state_r == tpsr_pkg::PL_SHIFT;
    // Preload owns the array, so fabric writes are dropped until it is done.
    wire wr_fire = w_edge & wen_act & (w9 | w18) & ~res_act // [R1] [R2] [R8]
        & ~pl_busy;
    wire rd_fire = r_edge & ren_act & (r9 | r18) & ~res_act; // [R2] [R8]

    // Nine-bit address bit 0 picks the half: even words take the low half.
    wire [7:0] w_idx = w9 ? write_addr_bus_i[8:1] // [R16]
        : write_addr_bus_i[7:0];
    wire [7:0] r_idx = r9 ? read_addr_bus_i[8:1] // [R16]
        : read_addr_bus_i[7:0];
    wire [17:0] r_word = mem_r[r_idx];
    wire [8:0] r_half = read_addr_bus_i[0] ? r_word[17:9] : r_word[8:0];
    // Upper bits in nine-bit mode are don't-care; zero keeps them quiet.
    wire [17:0] rsel_word = r18 ? r_word : {9'h000, r_half}; // [R4]

    wire pl_wr = pl_busy & preload_shift_i & ce_i &
        (pl_bit_r == `TPSR_WORD_LAST);
    wire [17:0] pl_word = {preload_bit_i, shift_r[17:1]};
    // Rows hold eighteen bits, so the row index keeps its own count.
    wire [7:0] pl_idx = pl_row_r;
    assign wport_w.addr = pl_wr ? {1'b0, pl_idx} : {1'b0, w_idx};
    assign wport_w.data = pl_wr ? pl_word
        : (w9 ? {write_data_bus_i[8:0], write_data_bus_i[8:0]}
        : write_data_bus_i);
    wire mw_lo = pl_wr | (wr_fire & (w18 | ~write_addr_bus_i[0]));
    wire mw_hi = pl_wr | (wr_fire & (w18 | write_addr_bus_i[0]));

    // Memory rows are not touched by any reset.
    genvar ge;
    generate
        for (ge = 0; ge < 256; ge = ge + 1) begin : g_row
            always_ff @(posedge clk_i) begin
                if (mw_lo && wport_w.addr[7:0] == 8'(ge)) begin
                    mem_r[ge][8:0] <= wport_w.data[8:0]; // [R12] [R16]
                end
                if (mw_hi && wport_w.addr[7:0] == 8'(ge)) begin
                    mem_r[ge][17:9] <= wport_w.data[17:9]; // [R12] [R16]
                end
            end
        end
    endgenerate

    // Read port: address taken on the read edge, one or two edges to data.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_data_o <= 18'h0_0000;
            stage_r <= 18'h0_0000;
        end else if (ce_i) begin
            if (res_act) begin
                read_data_o <= 18'h0_0000; // [R8]
                stage_r <= 18'h0_0000; // [R8]
            end else if (r_edge && ctrl_r.pipe) begin
                read_data_o <= stage_r; // [R9] [R11]
                if (rd_fire) begin
                    stage_r <= rsel_word; // [R11]
                end
            end else if (rd_fire) begin
                read_data_o <= rsel_word; // [R9] [R10]
            end
        end
    end

    // Serial preload: bits arrive LSB first, eighteen to a row.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pl_state_r <= tpsr_pkg::PL_IDLE;
            pl_cnt_r <= 13'h0000;
            pl_bit_r <= 5'h00;
            pl_row_r <= 8'h00;
            shift_r <= 18'h0_0000;
            preload_done_o <= 1'b0;
        end else if (ce_i) begin
            case (pl_state_r)
                tpsr_pkg::PL_IDLE: begin
                    if (preload_sel_i) begin
                        pl_state_r <= tpsr_pkg::PL_SHIFT;
                        pl_cnt_r <= 13'h0000;
                        pl_bit_r <= 5'h00;
                        pl_row_r <= 8'h00;
                    end
                end
                tpsr_pkg::PL_SHIFT: begin
                    if (preload_shift_i) begin
                        shift_r <= pl_word; // [R15]
                        pl_cnt_r <= pl_cnt_r + 13'h0001;
                        pl_bit_r <= pl_wr ? 5'h00 : pl_bit_r + 5'h01;
                        if (pl_wr) begin
                            pl_row_r <= pl_row_r + 8'h01;
                        end
                        if (pl_cnt_r == `TPSR_PRELOAD_BITS - 13'h0001) begin
                            pl_state_r <= tpsr_pkg::PL_DONE; // [R15]
                            preload_done_o <= 1'b1;
                        end
                    end
                end
                tpsr_pkg::PL_DONE: begin
                    if (!preload_sel_i) begin
                        pl_state_r <= tpsr_pkg::PL_IDLE;
                    end
                end
                default: begin
                    pl_state_r <= tpsr_pkg::PL_IDLE;
                end
            endcase
        end
    end

    // Wishbone slave: ack one cycle after the strobe, dropped the next.
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire hit_ctrl = wb_adr_i == `TPSR_CTRL_OFS;
    wire hit_stat = wb_adr_i == `TPSR_STAT_OFS;
    wire [31:0] stat_w = {10'h000, read_data_o, 1'b0, pl_busy, res_act,
        preload_done_o};
    wire [31:0] rdat_w = hit_ctrl ? {23'h00_0000, ctrl_r}
        : (hit_stat ? stat_w : 32'h0000_0000);
    wire [8:0] ctrl_wr = {wb_sel_i[1] ? wb_dat_i[8] : ctrl_r[8],
        wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_r[7:0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r <= `TPSR_CTRL_RST;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rdat_w : 32'h0000_0000;
            if (wb_req && wb_we_i && hit_ctrl) begin
                ctrl_r <= ctrl_wr; // [R7] [R9] [R13]
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_pipe_issue;
        rd_fire && ctrl_r.pipe;
    endsequence
    sequence s_next_edge;
        r_edge && !res_act && ctrl_r.pipe;
    endsequence

    AST_RESET_ZERO: assert property ( // [R8]
        res_act && ce_i |=> read_data_o == 18'h0_0000 && stage_r == 18'h0_0000)
        else $error("read output not cleared in reset");
    AST_RESET_NO_WRITE: assert property (res_act |-> !wr_fire) // [R8]
        else $error("write accepted during reset");
    AST_RESERVED_BLOCK: assert property ( // [R2]
        !(w9 || w18) |-> !wr_fire)
        else $error("write accepted with reserved width");
    AST_ENABLE_POL: assert property ( // [R7]
        rd_fire |-> read_en_i == ctrl_r.ren_high)
        else $error("read fired with inactive enable level");
    AST_FLOW_READ: assert property ( // [R10]
        rd_fire && !ctrl_r.pipe |=> read_data_o == $past(rsel_word))
        else $error("flow-through read data wrong");
    AST_PIPE_STAGE: assert property ( // [R11]
        s_pipe_issue |=> stage_r == $past(rsel_word))
        else $error("pipelined word not registered");
    AST_PIPE_OUT: assert property ( // [R9]
        s_next_edge |=> read_data_o == $past(stage_r))
        else $error("pipelined data not shown at next edge");
    AST_WRITE18: assert property ( // [R12]
        wr_fire && w18 |=> mem_r[$past(w_idx)] == $past(write_data_bus_i))
        else $error("eighteen-bit write not stored");
    AST_LITTLE_END: assert property ( // [R16]
        wr_fire && w9 && !write_addr_bus_i[0]
        |=> mem_r[$past(w_idx)][8:0] == $past(write_data_bus_i[8:0]))
        else $error("even nine-bit word not in low half");
    AST_NINE_HIGH: assert property ( // [R4]
        rd_fire && r9 && !ctrl_r.pipe |=> read_data_o[17:9] == 9'h000)
        else $error("nine-bit read upper bits not zero");

    sequence s_wb_take;
        wb_req && ce_i;
    endsequence
    sequence s_preload_last;
        pl_busy && preload_shift_i && ce_i
        && pl_cnt_r == `TPSR_PRELOAD_BITS - 13'h0001;
    endsequence

    // Bus checks: ack is a single-cycle pulse tied to a taken request.
    AST_ACK_TAKE: assert property (s_wb_take |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("acknowledge held past one cycle");
    AST_ACK_IDLE: assert property (!wb_req && ce_i |=> !wb_ack_o)
        else $error("acknowledge without a request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("bus read data not zero outside acknowledge");
    AST_CTRL_WRITE: assert property ( // [R7] [R13]
        s_wb_take ##0 (wb_we_i && hit_ctrl && (&wb_sel_i[1:0]))
        |=> ctrl_r == $past(wb_dat_i[8:0]))
        else $error("control write not stored");
    AST_UNMAPPED_READ: assert property (
        s_wb_take ##0 (!hit_ctrl && !hit_stat)
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read returned data");

    // Preload checks: rows land whole and done is reached once, then kept.
    AST_PRELOAD_ROW: assert property ( // [R15]
        pl_wr |=> mem_r[$past(pl_idx)] == $past(pl_word))
        else $error("preload row not stored");
    AST_PRELOAD_DONE: assert property ( // [R15]
        s_preload_last |=> preload_done_o && !pl_busy)
        else $error("preload not finished after last bit");
    AST_DONE_KEPT: assert property ( // [R15]
        preload_done_o |=> preload_done_o)
        else $error("preload done dropped");
    AST_PRELOAD_OWNS: assert property (pl_busy |-> !wr_fire) // [R15]
        else $error("fabric write during preload");

    // Port checks: nine-bit halves, eighteen-bit words, stable output.
    AST_WRITE9_HIGH: assert property ( // [R16]
        wr_fire && w9 && write_addr_bus_i[0]
        |=> mem_r[$past(w_idx)][17:9] == $past(write_data_bus_i[8:0]))
        else $error("odd nine-bit word not in high half");
    AST_WRITE9_KEEP: assert property ( // [R16]
        wr_fire && w9 && !write_addr_bus_i[0]
        |=> mem_r[$past(w_idx)][17:9] == $past(mem_r[w_idx][17:9]))
        else $error("even nine-bit write disturbed the high half");
    AST_RESERVED_READ: assert property ( // [R2]
        !(r9 || r18) |-> !rd_fire)
        else $error("read accepted with reserved width");
    AST_RESET_NO_READ: assert property (res_act |-> !rd_fire) // [R8]
        else $error("read accepted during reset");
    AST_READ18: assert property ( // [R10]
        rd_fire && r18 && !ctrl_r.pipe |=> read_data_o == $past(r_word))
        else $error("eighteen-bit read word wrong");
    AST_OUT_HOLD: assert property ( // [R9]
        ce_i && !res_act && !r_edge |=> $stable(read_data_o))
        else $error("read output moved without a read edge");
    AST_STAGE_HOLD: assert property ( // [R11]
        ce_i && !res_act && !rd_fire |=> $stable(stage_r))
        else $error("pipeline stage moved without a read");
    AST_W_ONE_EDGE: assert property (w_edge |=> !w_edge) // [R6]
        else $error("write edge seen on two cycles");
    AST_R_FILTER: assert property ( // [R6] [R13]
        r_edge |-> sync_r[2][1] == sync_r[2][2])
        else $error("read edge taken before the pin settled");
    AST_CE_FREEZE: assert property (
        !ce_i |=> $stable(ctrl_r) && $stable(read_data_o)
        && $stable(pl_cnt_r) && $stable(filt_r))
        else $error("state moved while the clock enable was low");
endmodule

// ==== verif/tpsr_fabric.sv ====
// Fabric-side model that drives the write and read ports of the memory.
`timescale 1ns/1ns
module tpsr_fabric (
    input wire logic clk_i,
    output logic write_clk_o,
    output logic read_clk_o,
    output logic write_en_o,
    output logic read_en_o,
    output logic [8:0] write_addr_o,
    output logic [17:0] write_data_o,
    output logic [8:0] read_addr_o
);
    initial begin
        {write_clk_o, read_clk_o, write_en_o, read_en_o} = 4'h3;
        {write_addr_o, write_data_o, read_addr_o} = 36'h0_0000_0000;
    end
    // Port clock pins are filtered, so each phase is held well past the filter.
    task automatic wr(input logic [8:0] a, input logic [17:0] d,
                      input logic en);
        @(posedge clk_i);
        {write_addr_o, write_data_o, write_en_o} <= {a, d, en};
        @(posedge clk_i);
        write_clk_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        write_clk_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        // Released lines show the inverse so stale values cannot pass.
        {write_addr_o, write_data_o, write_en_o} <= {~a, ~d, ~en};
    endtask
    task automatic rd(input logic [8:0] a, input logic en);
        @(posedge clk_i);
        {read_addr_o, read_en_o} <= {a, en};
        @(posedge clk_i);
        read_clk_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        read_clk_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        {read_addr_o, read_en_o} <= {~a, ~en};
    endtask
endmodule

// ==== verif/tpsr_top_tb_top.sv ====
// Self-checking bench for the two-port SRAM block.
`timescale 1ns/1ns
module tpsr_top_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic reset_n = 1'b1;
    logic ce = 1'b1;
    logic sel = 1'b0;
    logic shift = 1'b0;
    logic pbit = 1'b0;
    logic [31:0] q, wb_dat_o;
    logic wb_ack_o, done, b, wclk, rclk, wen, ren;
    logic [8:0] write_addr_bus, read_addr_bus, a;
    logic [17:0] wdata, rdata, d, e;
    logic [17:0] mem [256];
    int miscompares = 0;
    int compares = 0;
    always #4 clk_i = ~clk_i;
    tpsr_top tpsr_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .reset_n_i(reset_n), .write_clk_i(wclk), .read_clk_i(rclk),
        .write_en_i(wen), .read_en_i(ren), .write_addr_bus_i(write_addr_bus),
        .write_data_bus_i(wdata), .read_addr_bus_i(read_addr_bus),
        .read_data_o(rdata), .preload_sel_i(sel), .preload_shift_i(shift),
        .preload_bit_i(pbit), .preload_done_o(done)
    );
    tpsr_fabric tpsr_fabric_i (
        .clk_i(clk_i), .write_clk_o(wclk), .read_clk_o(rclk),
        .write_en_o(wen), .read_en_o(ren), .write_addr_o(write_addr_bus),
        .write_data_o(wdata), .read_addr_o(read_addr_bus)
    );
    task automatic chk18(input logic [17:0] g, input logic [17:0] x);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("MISMATCH %0t read word %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("MISMATCH %0t bus value %h expected %h", $time, g, x);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] ad,
                      input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, we, adr, dat} <= {1'b1, w, ad, dt};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            $display("MISMATCH %0t bus acknowledge timed out", $time);
        end
        q = wb_dat_o;
        cyc <= 1'b0;
    endtask
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // The preload alone takes two cycles per bit, so allow for it.
    initial begin
        #(8 * 40000);
        miscompares++;
        close_out;
    end
    initial begin
        void'($urandom(84020));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(1'b0, 4'h0, 32'h0000_0000);
        chk32(q, 32'h0000_0005);
        wb(1'b1, 4'h8, 32'hFFFF_FFFF);
        wb(1'b0, 4'h8, 32'h0000_0000);
        chk32(q, 32'h0000_0000);
        sel <= 1'b1;
        for (int i = 0; i < 4608; i++) begin
            @(posedge clk_i);
            b = 1'($urandom);
            {shift, pbit} <= {1'b1, b};
            mem[i / 18][i % 18] = b;
            @(posedge clk_i);
            shift <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        chk32({31'h0000_0000, done}, 32'h0000_0001);
        wb(1'b0, 4'h4, 32'h0000_0000);
        chk32(q, 32'h0000_0001);
        sel <= 1'b0;
        wb(1'b1, 4'h0, 32'h0000_000A);
        for (int k = 0; k < 6; k++) begin
            a = {1'b0, 8'($urandom)};
            tpsr_fabric_i.rd(a, 1'b0);
            chk18(rdata, mem[a[7:0]]);
        end
        wb(1'b1, 4'h0, 32'h0000_0009);
        for (int k = 0; k < 6; k++) begin
            a = 9'($urandom);
            d = {9'h000, 9'($urandom)};
            tpsr_fabric_i.wr(a, d, 1'b0);
            mem[a[8:1]][a[0] * 9 +: 9] = d[8:0];
            tpsr_fabric_i.rd({1'b0, a[8:1]}, 1'b0);
            chk18(rdata, mem[a[8:1]]);
        end
        wb(1'b1, 4'h0, 32'h0000_0015);
        for (int k = 0; k < 4; k++) begin
            a = 9'($urandom);
            tpsr_fabric_i.rd(a, 1'b0);
            if (k > 0) chk18(rdata, e);
            e = {9'h000, mem[a[8:1]][a[0] * 9 +: 9]};
        end
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, 4'h0, k ? 32'h0000_01EA : 32'h0000_000A);
            a = {1'b0, 8'($urandom)};
            d = 18'($urandom);
            tpsr_fabric_i.wr(a, d, k[0]);
            tpsr_fabric_i.wr(a, ~d, !k[0]);
            mem[a[7:0]] = d;
            tpsr_fabric_i.rd(a, k[0]);
            chk18(rdata, mem[a[7:0]]);
        end
        ce <= 1'b0;
        repeat (4) @(posedge clk_i);
        ce <= 1'b1;
        reset_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk18(rdata, 18'h0_0000);
        wb(1'b0, 4'h4, 32'h0000_0000);
        chk32(q, 32'h0000_0003);
        tpsr_fabric_i.wr(a, ~d, 1'b1);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_i);
        tpsr_fabric_i.rd(a, 1'b1);
        chk18(rdata, mem[a[7:0]]);
        close_out;
    end
endmodule
